// >>> verilog/csdm_pkg.sv
// constants, types and helpers shared by the clock manager and its controller
// assumes a single system clock; both ends import the whole package
package csdm_pkg;

    // ****************************************
    // factor and phase limits
    // ****************************************
    localparam int                FACT_W    = 6;
    localparam logic [5:0]        MULT_MIN  = 6'h02;
    localparam logic [5:0]        MULT_MAX  = 6'h20;
    localparam logic [5:0]        DIV_MIN   = 6'h01;
    localparam logic [5:0]        DIV_MAX   = 6'h20;
    localparam int                PHASE_W   = 9;
    localparam logic signed [8:0] PHASE_MAX = 9'sh0FF;
    localparam logic signed [8:0] PHASE_MIN = 9'sh101;

    // ****************************************
    // status bus layout
    // ****************************************
    localparam int STATUS_W      = 8;
    localparam int ST_PS_LIMIT   = 0;
    localparam int ST_REF_LOST   = 1;
    localparam int ST_SYNTH_STOP = 2;
    localparam int ST_CFG_ERR    = 3;
    localparam int ST_RANGE_ERR  = 4;
    localparam int ST_TAP_LIMIT  = 5;

    // ****************************************
    // timing counts
    // ****************************************
    localparam int LOW_MIN_HALF = 4;
    localparam int LOCK_EDGES   = 4;

    // ****************************************
    // controller register map and resets
    // ****************************************
    localparam logic [4:0] REG_CTRL   = 5'h00;
    localparam logic [4:0] REG_MULT   = 5'h04;
    localparam logic [4:0] REG_DIV    = 5'h08;
    localparam logic [4:0] REG_PHASE  = 5'h0C;
    localparam logic [4:0] REG_STEP   = 5'h10;
    localparam logic [4:0] REG_STATUS = 5'h14;
    localparam int         CTRL_RST   = 0;
    localparam int         CTRL_FB    = 1;
    localparam int         CTRL_RANGE = 2;
    localparam int         STEP_GO    = 0;
    localparam int         STEP_INC   = 1;
    localparam int         STAT_LOCK  = 8;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam logic [5:0] MULT_RESET = 6'h02;
    localparam logic [5:0] DIV_RESET  = 6'h01;
    localparam logic [8:0] PHASE_RESET = 9'h000;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic {
        CSDM_RANGE_LOW  = 1'b0,
        CSDM_RANGE_HIGH = 1'b1
    } csdm_range_t;

    typedef enum logic [1:0] {
        CSDM_MEAS  = 2'b00,
        CSDM_TRACK = 2'b01,
        CSDM_LOCK  = 2'b11
    } csdm_state_t;

    function automatic logic csdm_mult_ok(input logic [5:0] m);
        return (m >= MULT_MIN) && (m <= MULT_MAX);
    endfunction

    function automatic logic csdm_div_ok(input logic [5:0] d);
        return (d >= DIV_MIN) && (d <= DIV_MAX);
    endfunction

    function automatic logic csdm_phase_ok(input logic signed [8:0] p);
        return (p >= PHASE_MIN) && (p <= PHASE_MAX);
    endfunction

endpackage

// >>> verilog/csdm_link_if.sv
// link between the clock manager and its controlling logic
// assumes both ends run on the same system clock
`timescale 1ns/1ns
interface csdm_link_if;
    import csdm_pkg::*;

    logic                ref_clk_in;
    logic                feedback_clk_in;
    logic                deskew_zero_phase_out;
    logic                synth_clk_out;
    logic                synth_clk_out_inverted;
    logic [FACT_W-1:0]   mult_factor;
    logic [FACT_W-1:0]   div_factor;
    csdm_range_t         synth_range_select;
    logic                fb_enable;
    logic [PHASE_W-1:0]  phase_fixed;
    logic                ps_step;
    logic                ps_inc;
    logic                mgr_rst;
    logic                locked;
    logic [STATUS_W-1:0] status;

    modport mgr (
        input  ref_clk_in,
        input  feedback_clk_in,
        input  mult_factor,
        input  div_factor,
        input  synth_range_select,
        input  fb_enable,
        input  phase_fixed,
        input  ps_step,
        input  ps_inc,
        input  mgr_rst,
        output deskew_zero_phase_out,
        output synth_clk_out,
        output synth_clk_out_inverted,
        output locked,
        output status
    );

    modport ctrl (
        output ref_clk_in,
        output feedback_clk_in,
        output mult_factor,
        output div_factor,
        output synth_range_select,
        output fb_enable,
        output phase_fixed,
        output ps_step,
        output ps_inc,
        output mgr_rst,
        input  deskew_zero_phase_out,
        input  synth_clk_out,
        input  synth_clk_out_inverted,
        input  locked,
        input  status
    );
endinterface

// >>> verilog/csdm_clock_manager.sv
// clock manager: deskew tap loop, fractional synthesizer, phase shifter, status
// assumes the reference and feedback arrive synchronous to clk
//
// Register access over Avalon-MM and the address map are this design's own decisions.
`timescale 1ns/1ns
module csdm_clock_manager
    import csdm_pkg::*;
#(
    parameter int TAPS       = 64,
    parameter int PER_W      = 16,
    parameter int LOCK_COUNT = LOCK_EDGES
) (
    input  wire logic clk,
    input  wire logic sys_rst,
    csdm_link_if.mgr  lk
);

    localparam int TAP_W = $clog2(TAPS);
    localparam int THR_W = PER_W + FACT_W;

    // ****************************************
    // reference sampling and period measure
    // ****************************************
    logic             ref_q;
    logic             ref_rise;
    logic [PER_W-1:0] per_cnt;
    logic [PER_W-1:0] per_meas;
    logic             ref_lost;

    assign ref_rise = lk.ref_clk_in & ~ref_q;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ref_q <= 1'b0;
        end else begin
            ref_q <= lk.ref_clk_in;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            per_cnt  <= '0;
            per_meas <= '0;
            ref_lost <= 1'b0;
        end else if (lk.mgr_rst) begin
            per_cnt  <= '0;
            per_meas <= '0;
            ref_lost <= 1'b0;
        end else if (ref_rise) begin
            per_meas <= per_cnt + 1'b1;
            per_cnt  <= '0;
            ref_lost <= 1'b0;
        end else if (&per_cnt) begin
            ref_lost <= 1'b1;
        end else begin
            per_cnt <= per_cnt + 1'b1;
        end
    end

    // ****************************************
    // configuration checks
    // ****************************************
    logic             cfg_ok;
    logic [THR_W-1:0] thr;
    logic [THR_W-1:0] step2;
    logic             fast_ok;
    logic             range_ok;
    logic             synth_ok;

    assign cfg_ok   = csdm_mult_ok(lk.mult_factor) && csdm_div_ok(lk.div_factor);
    assign thr      = THR_W'(lk.div_factor) * THR_W'(per_meas);
    assign step2    = THR_W'({lk.mult_factor, 1'b0});
    assign fast_ok  = (per_meas != '0) && (thr >= step2);
    assign range_ok = (lk.synth_range_select == CSDM_RANGE_HIGH) ||
                      (thr >= THR_W'(step2 * THR_W'(LOW_MIN_HALF)));
    assign synth_ok = cfg_ok && fast_ok && range_ok && !ref_lost;

    // ****************************************
    // deskew tap line and phase detector
    // ****************************************
    logic [TAPS-1:0]  tap_line;
    logic [TAP_W-1:0] tap_sel;
    logic             fb_q;
    logic             fb_aligned;
    logic [3:0]       align_cnt;
    csdm_state_t      state;

    assign fb_aligned = lk.feedback_clk_in & ~fb_q;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tap_line                 <= '0;
            fb_q                     <= 1'b0;
            lk.deskew_zero_phase_out <= 1'b0;
        end else begin
            tap_line                 <= {tap_line[TAPS-2:0], lk.ref_clk_in};
            fb_q                     <= lk.feedback_clk_in;
            lk.deskew_zero_phase_out <= tap_line[tap_sel];
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tap_sel <= '0;
        end else if (lk.mgr_rst || !lk.fb_enable) begin
            tap_sel <= '0;
        end else if (state != CSDM_MEAS && ref_rise && !fb_aligned) begin
            // one tap later per missed edge, wrapping past the top
            if (tap_sel == TAP_W'(TAPS - 1)) begin
                tap_sel <= '0;
            end else begin
                tap_sel <= tap_sel + 1'b1;
            end
        end
    end

    // ****************************************
    // lock state machine
    // ****************************************
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state     <= CSDM_MEAS;
            align_cnt <= '0;
        end else if (lk.mgr_rst || !synth_ok) begin
            state     <= CSDM_MEAS;
            align_cnt <= '0;
        end else begin
            unique case (state)
                CSDM_MEAS: begin
                    align_cnt <= '0;
                    if (ref_rise) begin
                        state <= lk.fb_enable ? CSDM_TRACK : CSDM_LOCK;
                    end
                end
                CSDM_TRACK: begin
                    if (!lk.fb_enable) begin
                        state <= CSDM_LOCK;
                    end else if (ref_rise) begin
                        if (!fb_aligned) begin
                            align_cnt <= '0;
                        end else if (align_cnt == 4'(LOCK_COUNT - 1)) begin
                            state <= CSDM_LOCK;
                        end else begin
                            align_cnt <= align_cnt + 1'b1;
                        end
                    end
                end
                CSDM_LOCK: begin
                    if (lk.fb_enable && ref_rise && !fb_aligned) begin
                        state     <= CSDM_TRACK;
                        align_cnt <= '0;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // phase shifter
    // ****************************************
    logic signed [8:0] ps_net;
    logic signed [9:0] ph_sum;
    logic signed [9:0] ph_clamp;
    logic [9:0]        ph_offset;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ps_net <= '0;
        end else if (lk.mgr_rst) begin
            ps_net <= '0;
        end else if (lk.ps_step) begin
            if (lk.ps_inc && ps_net != PHASE_MAX) begin
                ps_net <= ps_net + 9'sh001;
            end else if (!lk.ps_inc && ps_net != PHASE_MIN) begin
                ps_net <= ps_net - 9'sh001;
            end
        end
    end

    assign ph_sum = 10'(signed'(lk.phase_fixed)) + 10'(ps_net);

    always_comb begin
        if (ph_sum > 10'(PHASE_MAX)) begin
            ph_clamp = 10'(PHASE_MAX);
        end else if (ph_sum < 10'(PHASE_MIN)) begin
            ph_clamp = 10'(PHASE_MIN);
        end else begin
            ph_clamp = ph_sum;
        end
    end

    assign ph_offset = 10'(ph_clamp - 10'(PHASE_MIN));

    // ****************************************
    // frequency synthesizer
    // ****************************************
    logic [FACT_W-1:0] ref_cnt;
    logic [THR_W:0]    acc;
    logic [THR_W:0]    next_acc;
    logic              realign;

    assign realign  = ref_rise && (ref_cnt == '0);
    assign next_acc = acc + (THR_W + 1)'(step2);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ref_cnt <= '0;
        end else if (lk.mgr_rst || !synth_ok) begin
            ref_cnt <= '0;
        end else if (ref_rise) begin
            ref_cnt <= (ref_cnt == lk.div_factor - 1'b1) ? '0 : ref_cnt + 1'b1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            acc                       <= '0;
            lk.synth_clk_out          <= 1'b0;
            lk.synth_clk_out_inverted <= 1'b1;
        end else if (lk.mgr_rst || !synth_ok || state == CSDM_MEAS) begin
            acc                       <= '0;
            lk.synth_clk_out          <= 1'b0;
            lk.synth_clk_out_inverted <= 1'b1;
        end else if (realign) begin
            acc <= ((THR_W + 1)'(ph_offset) < (THR_W + 1)'(thr)) ? (THR_W + 1)'(ph_offset) : '0;
            lk.synth_clk_out          <= 1'b1;
            lk.synth_clk_out_inverted <= 1'b0;
        end else if (next_acc >= (THR_W + 1)'(thr)) begin
            acc                       <= next_acc - (THR_W + 1)'(thr);
            lk.synth_clk_out          <= ~lk.synth_clk_out;
            lk.synth_clk_out_inverted <= lk.synth_clk_out;
        end else begin
            acc <= next_acc;
        end
    end

    // ****************************************
    // status logic
    // ****************************************
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lk.locked <= 1'b0;
            lk.status <= '0;
        end else if (lk.mgr_rst) begin
            lk.locked <= 1'b0;
            lk.status <= '0;
        end else begin
            lk.locked                   <= (state == CSDM_LOCK) && synth_ok;
            lk.status                   <= '0;
            lk.status[ST_PS_LIMIT]      <= (ps_net == PHASE_MAX) || (ps_net == PHASE_MIN);
            lk.status[ST_REF_LOST]      <= ref_lost;
            lk.status[ST_SYNTH_STOP]    <= !synth_ok;
            lk.status[ST_CFG_ERR]       <= !cfg_ok;
            lk.status[ST_RANGE_ERR]     <= cfg_ok && (!fast_ok || !range_ok);
            lk.status[ST_TAP_LIMIT]     <= lk.fb_enable && (tap_sel == TAP_W'(TAPS - 1));
        end
    end

endmodule

// >>> verilog/csdm_controller.sv
// controlling logic for the clock manager, reached by software over avalon-mm
// assumes a single clock; makes the reference and closes the feedback path
`timescale 1ns/1ns
module csdm_controller
    import csdm_pkg::*;
#(
    parameter int REF_HALF   = 32,
    parameter int DIST_DELAY = 3
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    csdm_link_if.ctrl        lk
);

    // ****************************************
    // reference divider and feedback route
    // ****************************************
    logic [15:0]           ref_div;
    logic [DIST_DELAY-1:0] dist_line;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ref_div       <= '0;
            lk.ref_clk_in <= 1'b0;
        end else if (ref_div == 16'(REF_HALF - 1)) begin
            ref_div       <= '0;
            lk.ref_clk_in <= ~lk.ref_clk_in;
        end else begin
            ref_div <= ref_div + 1'b1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            dist_line          <= '0;
            lk.feedback_clk_in <= 1'b0;
        end else begin
            dist_line          <= {dist_line[DIST_DELAY-2:0], lk.deskew_zero_phase_out};
            lk.feedback_clk_in <= lk.fb_enable & dist_line[DIST_DELAY-1];
        end
    end

    // ****************************************
    // avalon-mm slave
    // ****************************************
    logic take;

    assign take = avs_write && !avs_waitrequest;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= '0;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
            avs_readdata    <= '0;
            if (avs_read && avs_waitrequest) begin
                unique case (avs_address)
                    REG_CTRL:   avs_readdata <= {29'h0, lk.synth_range_select,
                                                 lk.fb_enable, lk.mgr_rst};
                    REG_MULT:   avs_readdata <= {26'h0, lk.mult_factor};
                    REG_DIV:    avs_readdata <= {26'h0, lk.div_factor};
                    REG_PHASE:  avs_readdata <= 32'(signed'(lk.phase_fixed));
                    REG_STATUS: avs_readdata <= {23'h0, lk.locked, lk.status};
                    default:    avs_readdata <= '0;
                endcase
            end
        end
    end

    // ****************************************
    // control registers
    // ****************************************
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lk.mgr_rst            <= CTRL_RESET[CTRL_RST];
            lk.fb_enable          <= CTRL_RESET[CTRL_FB];
            lk.synth_range_select <= csdm_range_t'(CTRL_RESET[CTRL_RANGE]);
        end else if (take && avs_address == REG_CTRL) begin
            lk.mgr_rst            <= avs_writedata[CTRL_RST];
            lk.fb_enable          <= avs_writedata[CTRL_FB];
            lk.synth_range_select <= csdm_range_t'(avs_writedata[CTRL_RANGE]);
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lk.mult_factor <= MULT_RESET;
            lk.div_factor  <= DIV_RESET;
            lk.phase_fixed <= PHASE_RESET;
        end else if (take) begin
            if (avs_address == REG_MULT && avs_writedata[31:6] == '0 &&
                csdm_mult_ok(avs_writedata[5:0])) begin
                lk.mult_factor <= avs_writedata[5:0];
            end
            if (avs_address == REG_DIV && avs_writedata[31:6] == '0 &&
                csdm_div_ok(avs_writedata[5:0])) begin
                lk.div_factor <= avs_writedata[5:0];
            end
            if (avs_address == REG_PHASE && csdm_phase_ok(avs_writedata[8:0])) begin
                lk.phase_fixed <= avs_writedata[8:0];
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lk.ps_step <= 1'b0;
            lk.ps_inc  <= 1'b0;
        end else if (take && avs_address == REG_STEP) begin
            lk.ps_step <= avs_writedata[STEP_GO];
            lk.ps_inc  <= avs_writedata[STEP_INC];
        end else begin
            lk.ps_step <= 1'b0;
        end
    end

endmodule

// >>> dv/csdm_monitor.sv
// checker on the link between clock manager and controller
// assumes one clock; link signals come straight from the interface
`timescale 1ns/1ns
module csdm_monitor
    import csdm_pkg::*;
#(
    parameter int DIST_DELAY = 3
) (
    input wire logic                clk,
    input wire logic                sys_rst,
    input wire logic                ref_clk_in,
    input wire logic                feedback_clk_in,
    input wire logic                deskew_zero_phase_out,
    input wire logic                synth_clk_out,
    input wire logic                synth_clk_out_inverted,
    input wire logic                fb_enable,
    input wire logic                mgr_rst,
    input wire logic                locked,
    input wire logic [STATUS_W-1:0] status
);
    // ****************************************
    // link properties
    // ****************************************
    localparam int FBD = DIST_DELAY + 1;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_inv; synth_clk_out_inverted == !synth_clk_out; endproperty
    a_inv: assert property (p_inv) else $error("inverted output wrong");
    property p_top; status[7:6] == 2'b00; endproperty
    a_top: assert property (p_top) else $error("status top bits set");
    property p_rst_st; mgr_rst |=> status == 8'h00; endproperty
    a_rst_st: assert property (p_rst_st) else $error("status kept in reset");
    property p_rst_lk; mgr_rst |=> !locked; endproperty
    a_rst_lk: assert property (p_rst_lk) else $error("lock kept in reset");
    property p_lk_wait; $fell(mgr_rst) |-> !locked [*8]; endproperty
    a_lk_wait: assert property (p_lk_wait) else $error("lock too early");
    property p_fb_on; fb_enable [*5] |-> feedback_clk_in == $past(deskew_zero_phase_out, FBD);
    endproperty
    a_fb_on: assert property (p_fb_on) else $error("feedback path wrong");
    property p_fb_off; !fb_enable [*5] |-> !feedback_clk_in; endproperty
    a_fb_off: assert property (p_fb_off) else $error("feedback while off");
    property p_ref; $changed(ref_clk_in) |=> $stable(ref_clk_in) [*8]; endproperty
    a_ref: assert property (p_ref) else $error("reference too short");
endmodule

// >>> dv/testbench.sv
// self-checking bench: controller and clock manager joined by the link
// assumes avalon-mm software access and a 125 MHz clock
`timescale 1ns/1ns
module testbench;
    import csdm_pkg::*;
    // ****************************************
    // signals, instances, tasks
    // ****************************************
    localparam int RH = 32;
    localparam int DD = 3;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [4:0]  avs_address = 5'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [31:0] rd;
    int          error_cnt = 0;
    int          check_count = 0;
    csdm_link_if lk ();
    csdm_controller #(.REF_HALF(RH), .DIST_DELAY(DD)) csdm_controller_inst (
        .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .lk(lk.ctrl));
    csdm_clock_manager csdm_clock_manager_inst (.clk(clk), .sys_rst(sys_rst), .lk(lk.mgr));
    csdm_monitor #(.DIST_DELAY(DD)) csdm_monitor_inst (.clk(clk), .sys_rst(sys_rst),
        .ref_clk_in(lk.ref_clk_in), .feedback_clk_in(lk.feedback_clk_in),
        .deskew_zero_phase_out(lk.deskew_zero_phase_out), .synth_clk_out(lk.synth_clk_out),
        .synth_clk_out_inverted(lk.synth_clk_out_inverted), .fb_enable(lk.fb_enable),
        .mgr_rst(lk.mgr_rst), .locked(lk.locked), .status(lk.status));
    always #4 clk = ~clk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        avs_write     <= wr;
        avs_read      <= !wr;
        avs_address   <= a;
        avs_writedata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        if (n >= 50) begin
            error_cnt++;
            $display("[ERR] %0t bus hang", $time);
        end
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask
    task automatic rdchk(input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic wrchk(input logic [4:0] a, input logic [31:0] d, input logic [31:0] e);
        bus(1'b1, a, d);
        rdchk(a, e);
    endtask
    task automatic poll(input int b, input logic v);
        int n = 0;
        do begin
            bus(1'b0, REG_STATUS, 32'h0);
            n++;
        end while (rd[b] !== v && n < 3000);
        chk(32'(rd[b]), 32'(v));
    endtask
    task automatic t_synth(input logic [31:0] c, input logic [31:0] m, input logic [31:0] d,
                           input int cyc, input int e);
        logic p;
        int   n = 0;
        bus(1'b1, REG_MULT, m);
        bus(1'b1, REG_DIV, d);
        bus(1'b1, REG_CTRL, c);
        poll(STAT_LOCK, 1'b1);
        p = lk.synth_clk_out;
        repeat (cyc) begin
            @(posedge clk);
            if (lk.synth_clk_out === 1'b1 && p === 1'b0) n++;
            p = lk.synth_clk_out;
        end
        chk(32'(n), 32'(e));
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        rdchk(REG_CTRL, 32'h0);
        rdchk(5'h18, 32'h0);
        rdchk(REG_STEP, 32'h0);
        wrchk(REG_MULT, 32'h01, 32'h02);
        wrchk(REG_MULT, 32'h21, 32'h02);
        wrchk(REG_MULT, 32'h45, 32'h02);
        wrchk(REG_MULT, 32'h20, 32'h20);
        wrchk(REG_DIV, 32'h00, 32'h01);
        wrchk(REG_DIV, 32'h21, 32'h01);
        wrchk(REG_DIV, 32'h20, 32'h20);
        wrchk(REG_PHASE, 32'h100, 32'h0);
        wrchk(REG_PHASE, 32'h101, 32'hFFFFFF01);
        wrchk(REG_PHASE, 32'hFF, 32'hFF);
        bus(1'b1, REG_DIV, 32'h01);
        poll(ST_RANGE_ERR, 1'b1);
        bus(1'b1, REG_CTRL, 32'h04);
        poll(ST_RANGE_ERR, 1'b0);
        t_synth(32'h0, 32'h2, 32'h1, 4 * RH, 4);
        t_synth(32'h2, 32'h5, 32'h3, 6 * RH, 5);
        bus(1'b1, REG_CTRL, 32'h03);
        rdchk(REG_STATUS, 32'h0);
        rdchk(REG_MULT, 32'h05);
        bus(1'b1, REG_CTRL, 32'h02);
        poll(STAT_LOCK, 1'b1);
        repeat (300) bus(1'b1, REG_STEP, 32'h3);
        poll(ST_PS_LIMIT, 1'b1);
        bus(1'b1, REG_STEP, 32'h1);
        poll(ST_PS_LIMIT, 1'b0);
        repeat (600) bus(1'b1, REG_STEP, 32'h1);
        poll(ST_PS_LIMIT, 1'b1);
        end_sim();
    end
    initial begin
        #600000;
        error_cnt++;
        $display("[ERR] %0t watchdog expired", $time);
        end_sim();
    end
endmodule
